/* File: hdl/tms_pkg.sv */
// constants and types shared by the interval measurement sequencer
package tms_pkg;
    // field widths
    localparam int RES_W = 20;
    localparam int FINE_W = 12;
    localparam int SUM_W = FINE_W + 1;
    localparam int COARSE_W = 12;
    localparam int CNT_W = 16;
    localparam int AV_W = 8;
    localparam int HB_W = 3;
    localparam int GC_W = 4;
    localparam int TR_W = 2;
    localparam int CAL_W = 4;
    localparam int WIDE_W = COARSE_W + SUM_W + 1;
    // cycle scheduling
    localparam logic [CNT_W-1:0] BRIDGE_CYC_MULT = 16'h0008;
    localparam logic [CNT_W-1:0] TEMP_CYC = 16'h0002;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [TR_W-1:0] TEMP_OFF = 2'h0;
    // reference period in fine lsb for the uncalibrated range, plain defaults
    localparam logic [SUM_W-1:0] PER_LSB_SINGLE = 13'h06f9;
    localparam logic [SUM_W-1:0] PER_LSB_HIRES = 13'h0df2;
    localparam logic [COARSE_W-1:0] COARSE_ONE = 12'h001;
    localparam logic [CAL_W-1:0] CAL_ZERO = 4'h0;
    localparam logic [CAL_W-1:0] CAL_ONE = 4'h1;
    // converter states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RUN = 4'h2,
        ST_CAL1 = 4'h4,
        ST_CAL2 = 4'h8
    } tms_state_t;
endpackage : tms_pkg

/* File: hdl/tms_fine_combiner.sv */
// fine code from code_a alone, or the sum of both delay-line positions when high resolution is selected
`timescale 1ns/10ps
module tms_fine_combiner import tms_pkg::*; (
    // clock and reset, used by checks only
    input wire logic ref_clk,
    input wire logic reset,
    // delay-line positions
    input wire logic [FINE_W-1:0] code_a,
    input wire logic [FINE_W-1:0] code_b,
    input wire logic high_resolution_select,
    // combined fine code
    output logic [SUM_W-1:0] fine_sum
);
    always_comb begin
        if (high_resolution_select) begin
            fine_sum = SUM_W'(code_a) + SUM_W'(code_b);
        end else begin
            fine_sum = SUM_W'(code_a);
        end
    end

    property p_hires_sum;
        @(posedge ref_clk) disable iff (reset)
        high_resolution_select |-> fine_sum == {1'b0, code_a} + {1'b0, code_b};
    endproperty
    a_hires_sum: assert property (p_hires_sum) else $error("high-res fine code not the sum");
endmodule : tms_fine_combiner

/* File: hdl/tms_cycle_timer.sv */
// measurement cycle timer, one tick per programmed period
`timescale 1ns/10ps
module tms_cycle_timer import tms_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // control
    input wire logic enable,
    input wire logic [CNT_W-1:0] cycle_period_count,
    // cycle boundary pulse
    output logic tick
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic tick;
    } tms_timer_t;

    tms_timer_t s_reg;
    tms_timer_t s_next;
    logic [CNT_W-1:0] gap_reg;
    logic seen_reg;

    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (!enable) begin
            s_next.cnt = '0;
        end else if (CNT_W'(s_reg.cnt + CNT_ONE) >= cycle_period_count) begin
            s_next.cnt = '0;
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt = CNT_W'(s_reg.cnt + CNT_ONE);
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;

    // spacing between ticks, for checking
    always_ff @(posedge ref_clk) begin
        if (reset || !enable) begin
            gap_reg <= '0;
            seen_reg <= 1'b0;
        end else if (s_reg.tick) begin
            gap_reg <= CNT_ONE;
            seen_reg <= 1'b1;
        end else begin
            gap_reg <= CNT_W'(gap_reg + CNT_ONE);
        end
    end

    property p_cycle_len;
        @(posedge ref_clk) disable iff (reset)
        (s_reg.tick && seen_reg && enable && cycle_period_count != '0 && $stable(cycle_period_count))
            |-> gap_reg == cycle_period_count;
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("cycle length differs from period count");
endmodule : tms_cycle_timer

/* File: hdl/tms_top.sv */
// interval converter core with measurement cycle scheduling
`timescale 1ns/10ps
module tms_top import tms_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // interval events
    input wire logic start_evt,
    input wire logic stop_evt,
    // delay-line positions
    input wire logic [FINE_W-1:0] fine_code_a,
    input wire logic [FINE_W-1:0] fine_code_b,
    // mode selection
    input wire logic second_range_select,
    input wire logic high_resolution_select,
    input wire logic [CAL_W-1:0] calibration_cycle_setting,
    // cycle scheduling
    input wire logic meas_enable,
    input wire logic [HB_W-1:0] half_bridges,
    input wire logic [AV_W-1:0] averaging_rate,
    input wire logic [GC_W-1:0] gain_correction_rate,
    input wire logic [TR_W-1:0] temperature_rate,
    input wire logic [CNT_W-1:0] cycle_period_count,
    // interval result
    output logic [RES_W-1:0] result,
    output logic result_valid,
    output logic busy,
    // calibration
    output logic cal_launch,
    output logic cal_active,
    output logic [SUM_W-1:0] period_lsb,
    // schedule status
    output logic cycle_tick,
    output logic meas_done,
    output logic temp_cycle,
    output logic [CNT_W-1:0] cycles_per_meas
);
    typedef struct packed {
        tms_state_t st;
        logic [COARSE_W-1:0] coarse;
        logic [SUM_W-1:0] fine_start;
        logic [SUM_W-1:0] cal_t1;
        logic [SUM_W-1:0] period;
        logic [CAL_W-1:0] cal_cnt;
        logic [RES_W-1:0] result;
        logic valid;
        logic busy;
        logic cal_launch;
        logic [CNT_W-1:0] cyc_cnt;
        logic [CNT_W-1:0] cyc_total;
        logic [TR_W-1:0] temp_cnt;
        logic temp_now;
        logic meas_done;
        logic cal_act;
    } tms_core_t;

    tms_core_t s_reg;
    tms_core_t s_next;
    logic [SUM_W-1:0] fine_sum;
    logic tick;
    logic temp_due;
    logic cal_due;
    logic last_cycle;
    logic [SUM_W-1:0] per_use;
    logic [CNT_W-1:0] total_calc;
    logic [CNT_W-1:0] base_calc;
    logic [CNT_W-1:0] total_nx;
    logic [TR_W-1:0] temp_cnt_nx;
    logic temp_due_nx;
    logic [WIDE_W-1:0] wide_res;

    // fine code from one or two delay circuits
    tms_fine_combiner u_fine (
        .ref_clk(ref_clk),
        .reset(reset),
        .code_a(fine_code_a),
        .code_b(fine_code_b),
        .high_resolution_select(high_resolution_select),
        .fine_sum(fine_sum)
    );

    // measurement cycle boundaries
    tms_cycle_timer u_timer (
        .ref_clk(ref_clk),
        .reset(reset),
        .enable(meas_enable),
        .cycle_period_count(cycle_period_count),
        .tick(tick)
    );

    // temperature due when its divider is at zero; a disabled scheduler restarts the divider
    assign temp_due = (temperature_rate != TEMP_OFF) && ((s_reg.temp_cnt == '0) || !meas_enable);

    // divider value and slot for the measurement after this one
    assign temp_cnt_nx = (s_reg.temp_cnt == '0) ? TR_W'(temperature_rate - 2'h1)
        : TR_W'(s_reg.temp_cnt - 2'h1);
    assign temp_due_nx = (temperature_rate != TEMP_OFF) && (temp_cnt_nx == '0);

    assign base_calc = CNT_W'(CNT_W'(half_bridges) * CNT_W'(averaging_rate) * BRIDGE_CYC_MULT)
        + CNT_W'(gain_correction_rate);
    assign total_calc = base_calc + (temp_due ? TEMP_CYC : '0);
    assign total_nx = base_calc + (temp_due_nx ? TEMP_CYC : '0);

    assign last_cycle = (CNT_W'(s_reg.cyc_cnt + CNT_ONE) >= s_reg.cyc_total);

    assign per_use = second_range_select ? s_reg.period
        : (high_resolution_select ? PER_LSB_HIRES : PER_LSB_SINGLE);

    // start and stop spans to next edge
    // coarse count times the period, plus start fine code, minus stop fine code
    assign wide_res = WIDE_W'(s_reg.coarse) * WIDE_W'(per_use) + WIDE_W'(s_reg.fine_start) - WIDE_W'(fine_sum);

    assign cal_due = second_range_select && (s_reg.cal_cnt == CAL_ZERO) && !start_evt;

    // next-state logic for converter and scheduler
    always_comb begin
        s_next = s_reg;
        s_next.valid = 1'b0;
        s_next.cal_launch = 1'b0;
        s_next.meas_done = 1'b0;
        case (s_reg.st)
            ST_IDLE: begin
                if (start_evt) begin
                    s_next.st = ST_RUN;
                    s_next.coarse = '0;
                    s_next.fine_start = fine_sum;
                    s_next.busy = 1'b1;
                end else if (cal_due) begin
                    s_next.st = ST_CAL1;
                    s_next.cal_launch = 1'b1;
                    s_next.busy = 1'b1;
                end
            end
            ST_RUN: begin
                if (start_evt) begin
                    s_next.coarse = '0;
                    s_next.fine_start = fine_sum;
                end else if (stop_evt) begin
                    s_next.result = wide_res[RES_W-1:0];
                    s_next.valid = 1'b1;
                    s_next.st = ST_IDLE;
                    s_next.busy = 1'b0;
                    if (s_reg.cal_cnt != CAL_ZERO) begin
                        s_next.cal_cnt = CAL_W'(s_reg.cal_cnt - CAL_ONE);
                    end
                end else begin
                    s_next.coarse = COARSE_W'(s_reg.coarse + COARSE_ONE);
                end
            end
            ST_CAL1: begin
                s_next.cal_t1 = fine_sum;
                s_next.st = ST_CAL2;
            end
            ST_CAL2: begin
                s_next.period = SUM_W'(fine_sum - s_reg.cal_t1);
                s_next.cal_cnt = calibration_cycle_setting;
                s_next.st = ST_IDLE;
                s_next.busy = 1'b0;
            end
            default: begin
                s_next.st = ST_IDLE;
                s_next.busy = 1'b0;
            end
        endcase
        // calibration status kept in a flop of its own
        s_next.cal_act = (s_next.st == ST_CAL1) || (s_next.st == ST_CAL2);
        if (!meas_enable) begin
            s_next.cyc_cnt = '0;
            s_next.cyc_total = total_calc;
            s_next.temp_now = temp_due;
            s_next.temp_cnt = '0;
        end else if (tick) begin
            if (last_cycle) begin
                s_next.cyc_cnt = '0;
                s_next.meas_done = 1'b1;
                s_next.temp_cnt = temp_cnt_nx;
                s_next.cyc_total = total_nx;
                s_next.temp_now = temp_due_nx;
            end else begin
                s_next.cyc_cnt = CNT_W'(s_reg.cyc_cnt + CNT_ONE);
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_reg <= '0;
            s_reg.st <= ST_IDLE;
            s_reg.period <= PER_LSB_SINGLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from the state register, cycle_tick from the timer's register
    assign result = s_reg.result;
    assign result_valid = s_reg.valid;
    assign busy = s_reg.busy;
    assign cal_launch = s_reg.cal_launch;
    assign cal_active = s_reg.cal_act;
    assign period_lsb = s_reg.period;
    assign cycle_tick = tick;
    assign meas_done = s_reg.meas_done;
    assign temp_cycle = s_reg.temp_now;
    assign cycles_per_meas = s_reg.cyc_total;

    // checks
    sequence s_cal_walk;
        s_reg.st == ST_CAL1 ##1 s_reg.st == ST_CAL2 ##1 s_reg.st == ST_IDLE;
    endsequence

    property p_cycle_formula;
        @(posedge ref_clk) disable iff (reset)
        !meas_enable |=> cycles_per_meas == CNT_W'($past(half_bridges) * $past(averaging_rate) * BRIDGE_CYC_MULT
            + $past(gain_correction_rate) + ($past(temp_due) ? TEMP_CYC : '0));
    endproperty
    a_cycle_formula: assert property (p_cycle_formula) else $error("cycle count formula wrong");

    property p_meas_done;
        @(posedge ref_clk) disable iff (reset)
        (meas_enable && tick && last_cycle) |=> meas_done && s_reg.cyc_cnt == '0;
    endproperty
    a_meas_done: assert property (p_meas_done) else $error("measurement end missed");

    property p_temp_every;
        @(posedge ref_clk) disable iff (reset)
        (!meas_enable && temperature_rate == 2'h1) |=> temp_cycle
            && cycles_per_meas == CNT_W'($past(total_calc));
    endproperty
    a_temp_every: assert property (p_temp_every) else $error("temperature cycles missing");

    property p_start_run;
        @(posedge ref_clk) disable iff (reset)
        (start_evt && s_reg.st inside {ST_IDLE, ST_RUN}) |=> s_reg.st == ST_RUN && s_reg.coarse == '0
            && s_reg.fine_start == $past(fine_sum);
    endproperty
    a_start_run: assert property (p_start_run) else $error("start did not clear and open");

    property p_stop_result;
        @(posedge ref_clk) disable iff (reset)
        (s_reg.st == ST_RUN && stop_evt && !start_evt) |=> result_valid && s_reg.st == ST_IDLE
            && result == $past(wide_res[RES_W-1:0]);
    endproperty
    a_stop_result: assert property (p_stop_result) else $error("stop result wrong");

    property p_coarse_count;
        @(posedge ref_clk) disable iff (reset)
        (s_reg.st == ST_RUN && !start_evt && !stop_evt) |=> s_reg.coarse == COARSE_W'($past(s_reg.coarse) + 1);
    endproperty
    a_coarse_count: assert property (p_coarse_count) else $error("coarse count not stepping");

    property p_cal_walk;
        @(posedge ref_clk) disable iff (reset)
        (s_reg.st == ST_IDLE && cal_due) |=> cal_launch and s_cal_walk;
    endproperty
    a_cal_walk: assert property (p_cal_walk) else $error("calibration walk broken");

    property p_no_cal_range1;
        @(posedge ref_clk) disable iff (reset)
        (!second_range_select && s_reg.st == ST_IDLE) |=> !cal_active;
    endproperty
    a_no_cal_range1: assert property (p_no_cal_range1) else $error("calibration in first range");

    property p_temp_next;
        @(posedge ref_clk) disable iff (reset)
        (meas_enable && tick && last_cycle && temperature_rate == 2'h1) |=> temp_cycle;
    endproperty
    a_temp_next: assert property (p_temp_next) else $error("temperature slot missing after measurement");

    property p_cal_busy;
        @(posedge ref_clk) disable iff (reset)
        cal_active |-> busy && !result_valid;
    endproperty
    a_cal_busy: assert property (p_cal_busy) else $error("calibration without busy");
endmodule : tms_top

/* File: dv/tms_delay_line_model.sv */
// delay-line model: edge codes, or reference codes while calibrating
`timescale 1ns/10ps
module tms_delay_line_model import tms_pkg::*; (
    // converter calibration status
    input wire logic cal_launch,
    input wire logic cal_active,
    // edge codes and calibration codes
    input wire logic [FINE_W-1:0] meas_a,
    input wire logic [FINE_W-1:0] meas_b,
    input wire logic [FINE_W-1:0] cal_t1,
    input wire logic [FINE_W-1:0] cal_t2,
    // positions seen by the converter
    output logic [FINE_W-1:0] code_a,
    output logic [FINE_W-1:0] code_b
);
    always_comb begin
        code_a = meas_a;
        code_b = meas_b;
        if (cal_active) begin
            code_a = cal_launch ? cal_t1 : cal_t2;
            code_b = cal_launch ? cal_t1 : cal_t2;
        end
    end
endmodule : tms_delay_line_model

/* File: dv/test_tms_top.sv */
// self-checking bench for the interval measurement sequencer
`timescale 1ns/10ps
module test_tms_top import tms_pkg::*; ;
    // stimulus
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic start_evt = 1'b0, stop_evt = 1'b0;
    logic second_range_select = 1'b0;
    logic high_resolution_select = 1'b0;
    logic [CAL_W-1:0] calibration_cycle_setting = CAL_ONE;
    logic meas_enable = 1'b0;
    logic [HB_W-1:0] half_bridges = 3'h1;
    logic [AV_W-1:0] averaging_rate = 8'h01;
    logic [GC_W-1:0] gain_correction_rate = 4'h0;
    logic [TR_W-1:0] temperature_rate = TEMP_OFF;
    logic [CNT_W-1:0] cycle_period_count = CNT_ONE;
    logic [FINE_W-1:0] meas_a = 12'h000, meas_b = 12'h000;
    logic [FINE_W-1:0] cal_t1 = 12'h100, cal_t2 = 12'h300;
    // observed
    logic [FINE_W-1:0] fine_code_a, fine_code_b;
    logic [RES_W-1:0] result;
    logic [SUM_W-1:0] period_lsb;
    logic [CNT_W-1:0] cycles_per_meas;
    logic result_valid, busy, cal_launch, cal_active, cycle_tick, meas_done, temp_cycle;
    int failures = 0;
    int samples_checked = 0;
    int seed = 49488;
    int cal_seen = 0;

    tms_delay_line_model line_model (.cal_launch, .cal_active, .meas_a, .meas_b, .cal_t1, .cal_t2,
        .code_a(fine_code_a), .code_b(fine_code_b));
    tms_top dut (.ref_clk, .reset, .start_evt, .stop_evt, .fine_code_a, .fine_code_b, .second_range_select,
        .high_resolution_select, .calibration_cycle_setting, .meas_enable, .half_bridges, .averaging_rate,
        .gain_correction_rate, .temperature_rate, .cycle_period_count, .result, .result_valid, .busy,
        .cal_launch, .cal_active, .period_lsb, .cycle_tick, .meas_done, .temp_cycle, .cycles_per_meas);

    // 20 MHz reference clock
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    // counts calibration launches
    always @(posedge ref_clk) begin
        if (cal_launch === 1'b1) begin
            cal_seen++;
        end
    end

    // compare and report
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // fine code as the converter should combine it
    function automatic logic [SUM_W-1:0] fsum(input logic [FINE_W-1:0] a, b, input logic hr);
        return hr ? SUM_W'(a) + SUM_W'(b) : SUM_W'(a);
    endfunction : fsum

    // expected interval for a stop n cycles after start
    function automatic logic [RES_W-1:0] interval(input int n, input logic [SUM_W-1:0] p, f0, f1);
        return RES_W'(n - 1) * RES_W'(p) + RES_W'(f0) - RES_W'(f1);
    endfunction : interval

    // one clock, then the drive delay
    task automatic step;
        @(posedge ref_clk);
        #5;
    endtask : step

    // one interval, optionally restarted while running
    task automatic measure(input int n, input logic [SUM_W-1:0] p, input logic rs);
        logic [FINE_W-1:0] a0, b0, a1, b1;
        logic [RES_W-1:0] e;
        a0 = FINE_W'($random(seed));
        b0 = FINE_W'($random(seed));
        a1 = FINE_W'($random(seed));
        b1 = FINE_W'($random(seed));
        if (rs) begin
            start_evt = 1'b1;
            step();
            start_evt = 1'b0;
            step();
        end
        start_evt = 1'b1;
        meas_a = a0;
        meas_b = b0;
        step();
        start_evt = 1'b0;
        meas_a = ~a0;
        meas_b = ~b0;
        check(32'(busy), 32'h1, "busy after start");
        repeat (n - 1) step();
        stop_evt = 1'b1;
        meas_a = a1;
        meas_b = b1;
        step();
        stop_evt = 1'b0;
        meas_a = ~a1;
        meas_b = ~b1;
        e = interval(n, p, fsum(a0, b0, high_resolution_select), fsum(a1, b1, high_resolution_select));
        check(32'(result_valid), 32'h1, "result valid");
        check(32'(result), 32'(e), "interval");
        check(32'(busy), 32'h0, "busy after stop");
        step();
        check(32'(result_valid), 32'h0, "valid width");
    endtask : measure

    // wait for a calibration and check the period it yields
    task automatic await_cal(output logic [SUM_W-1:0] p);
        int k;
        k = 0;
        while (cal_launch !== 1'b1 && k < 20) begin
            step();
            k++;
        end
        check(32'(cal_launch), 32'h1, "calibration launch");
        check(32'(cal_active), 32'h1, "calibration active");
        repeat (2) step();
        check(32'(cal_active), 32'h0, "calibration ended");
        p = fsum(cal_t2, cal_t2, high_resolution_select) - fsum(cal_t1, cal_t1, high_resolution_select);
        check(32'(period_lsb), 32'(p), "calibrated lsb");
        check(32'(busy), 32'h0, "busy after calibration");
        cal_t1 = FINE_W'({$random(seed)} % 1024);
        cal_t2 = cal_t1 + FINE_W'(256 + {$random(seed)} % 1024);
    endtask : await_cal

    // verdict
    task automatic test_done;
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    // main sequence
    initial begin
        int n;
        int cpm;
        int cyc;
        int ticks;
        logic [SUM_W-1:0] exp_p;
        int sets [4];
        sets = '{1, 2, 10, 1};
        repeat (5) @(posedge ref_clk);
        #5;
        check(32'(period_lsb), 32'(PER_LSB_SINGLE), "lsb at reset");
        check(32'(result), 32'h0, "result at reset");
        reset = 1'b0;
        step();
        // first range: corner lengths, then random, some restarted
        for (int i = 0; i < 24; i++) begin
            high_resolution_select = 1'($random(seed));
            n = (i == 0) ? 1 : (i == 1) ? 4096 : 1 + {$random(seed)} % 40;
            measure(n, high_resolution_select ? PER_LSB_HIRES : PER_LSB_SINGLE, i % 4 == 3);
        end
        check(cal_seen, 0, "calibration in first range");
        // second range: results between calibrations follow the setting
        high_resolution_select = 1'b1;
        calibration_cycle_setting = CAL_W'(sets[0]);
        second_range_select = 1'b1;
        for (int s = 0; s < 3; s++) begin
            await_cal(exp_p);
            calibration_cycle_setting = CAL_W'(sets[s + 1]);
            for (int r = 0; r < sets[s]; r++) begin
                measure(1 + {$random(seed)} % 30, exp_p, 1'b0);
            end
        end
        await_cal(exp_p);
        second_range_select = 1'b0;
        // scheduler: cycle count, cycle length, temperature slot
        for (int i = 0; i < 4; i++) begin
            meas_enable = 1'b0;
            half_bridges = HB_W'(1 + {$random(seed)} % 3);
            averaging_rate = AV_W'(1 + {$random(seed)} % 3);
            gain_correction_rate = GC_W'({$random(seed)} % 4);
            temperature_rate = TR_W'(i % 2);
            cycle_period_count = CNT_W'(1 + {$random(seed)} % 4);
            cpm = half_bridges * averaging_rate * 8 + gain_correction_rate + 2 * (i % 2);
            repeat (3) step();
            check(32'(cycles_per_meas), 32'(cpm), "cycles per measurement");
            meas_enable = 1'b1;
            for (int m = 0; m < 2; m++) begin
                cyc = 0;
                ticks = 0;
                do begin
                    step();
                    cyc++;
                    if (cycle_tick === 1'b1) begin
                        ticks++;
                    end
                end while (meas_done !== 1'b1 && cyc < 2000);
            end
            check(cyc, cpm * cycle_period_count, "measurement length");
            check(ticks, cpm, "cycles counted");
            check(32'(temp_cycle), 32'(i % 2), "temperature slot");
        end
        meas_enable = 1'b0;
        test_done();
    end

    // watchdog well above the expected run length
    initial begin
        repeat (40000) @(posedge ref_clk);
        failures++;
        test_done();
    end
endmodule : test_tms_top
